/* hw/dual_path_input_mixer.v */
// front end of a two-channel feedback instrument: 2x2 mixing matrix,
// per-path input zeroing and offset, per-path output zeroing, offset, enable.
// assumes inputs and settings come from logic on clk_sys; the controller
// filters sit between first/secondControllerPath and ctrlOne/TwoSample outside this block.
// limitation: channel outputs take whatever the filters present at a tick,
// so a filter slower than one sample period shows a stale value.
//
// Notes on behaviour
// - two path samples are the 2x2 coefficient matrix times the input vector
// - path one = a*in1 + b*in2; path two = c*in1 + d*in2
// - coefficients span -20 to +20 inclusive; larger settings are clamped
// - step is 0.1 below magnitude 10, one whole unit from 10 to 20
// - two independent paths, each fed by one matrix output, live settings
// - each path issues samples at 2.5 MSa/s
// - open input switch replaces the path input with zero
// - programmable input offset, -1 to +1 V full scale, added to path input
// - open output switch forces the path output to zero
// - programmable output offset, -1 to +1 V full scale, added to output
// - per-channel output enable; cleared means channel does not drive output
// - reset command returns coefficients, offsets and switches to defaults
// - pre-controller tap carries the sample after the matrix, before the filter
`timescale 1ns/100ps
`default_nettype none
`include "input_mixer_consts.vh"

module dual_path_input_mixer (
  // clock and reset
  input  wire                        clk_sys,
  input  wire                        resetn,
  // input sample streams
  input  wire signed [`SAMPLE_W-1:0] inputOneSample,
  input  wire signed [`SAMPLE_W-1:0] inputTwoSample,
  // mixing coefficients, tenths (value 10 is unity)
  input  wire signed [`COEF_W-1:0]   coefA,
  input  wire signed [`COEF_W-1:0]   coefB,
  input  wire signed [`COEF_W-1:0]   coefC,
  input  wire signed [`COEF_W-1:0]   coefD,
  // per-path input and output settings
  input  wire                        inSwitchOne,
  input  wire                        inSwitchTwo,
  input  wire signed [`SAMPLE_W-1:0] inOffsetOne,
  input  wire signed [`SAMPLE_W-1:0] inOffsetTwo,
  input  wire                        outSwitchOne,
  input  wire                        outSwitchTwo,
  input  wire signed [`SAMPLE_W-1:0] outOffsetOne,
  input  wire signed [`SAMPLE_W-1:0] outOffsetTwo,
  input  wire                        outEnableOne,
  input  wire                        outEnableTwo,
  // settings reset command, one cycle
  input  wire                        settingsReset,
  // samples back from the controller filters
  input  wire signed [`SAMPLE_W-1:0] ctrlOneSample,
  input  wire signed [`SAMPLE_W-1:0] ctrlTwoSample,
  // sample strobe shared by all streams
  output reg                         sampleStrobe,
  // mixed, offset path samples into the controllers
  output reg  signed [`SAMPLE_W-1:0] firstControllerPath,
  output reg  signed [`SAMPLE_W-1:0] secondControllerPath,
  // pre-controller observation taps
  output reg  signed [`SAMPLE_W-1:0] prePathOne,
  output reg  signed [`SAMPLE_W-1:0] prePathTwo,
  // channel outputs and drive enables
  output reg  signed [`SAMPLE_W-1:0] chanOneOut,
  output reg  signed [`SAMPLE_W-1:0] chanTwoOut,
  output reg                         chanOneDrive,
  output reg                         chanTwoDrive
);

  // rate counter
  reg  [`RATE_CNT_W-1:0]       rateCnt_reg;
  wire                         tick;

  // settings held for a whole sample period
  reg  signed [`COEF_W-1:0]    cA_reg;
  reg  signed [`COEF_W-1:0]    cB_reg;
  reg  signed [`COEF_W-1:0]    cC_reg;
  reg  signed [`COEF_W-1:0]    cD_reg;
  reg                          inSw1_reg;
  reg                          inSw2_reg;
  reg                          outSw1_reg;
  reg                          outSw2_reg;
  reg                          en1_reg;
  reg                          en2_reg;
  reg  signed [`SAMPLE_W-1:0]  inOff1_reg;
  reg  signed [`SAMPLE_W-1:0]  inOff2_reg;
  reg  signed [`SAMPLE_W-1:0]  outOff1_reg;
  reg  signed [`SAMPLE_W-1:0]  outOff2_reg;
  reg                          pendReset_reg;

  // next values, all chosen in combinational blocks
  reg  [`RATE_CNT_W-1:0]       rateCnt_next;
  reg  signed [`COEF_W-1:0]    cA_next;
  reg  signed [`COEF_W-1:0]    cB_next;
  reg  signed [`COEF_W-1:0]    cC_next;
  reg  signed [`COEF_W-1:0]    cD_next;
  reg                          inSw1_next;
  reg                          inSw2_next;
  reg                          outSw1_next;
  reg                          outSw2_next;
  reg                          en1_next;
  reg                          en2_next;
  reg  signed [`SAMPLE_W-1:0]  inOff1_next;
  reg  signed [`SAMPLE_W-1:0]  inOff2_next;
  reg  signed [`SAMPLE_W-1:0]  outOff1_next;
  reg  signed [`SAMPLE_W-1:0]  outOff2_next;
  reg                          pendReset_next;

  // sample strobe every RATE_DIV clocks
  assign tick = (rateCnt_reg == `RATE_CNT_ZERO);

  // down-counter reload; reload value kept at counter width
  always @* begin
    rateCnt_next = tick ? `RATE_CNT_LAST : rateCnt_reg - `RATE_CNT_STEP;
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rateCnt_reg  <= `RATE_CNT_ZERO;
      sampleStrobe <= 1'b0;
    end else begin
      rateCnt_reg  <= rateCnt_next;
      sampleStrobe <= tick;
    end
  end

  // coefficient legalisation: clamp to +-20, snap to whole units above 10
  function signed [`COEF_W-1:0] legalCoef;
    input signed [`COEF_W-1:0] raw;
    reg signed [`COEF_W-1:0] c;
    reg signed [`COEF_W-1:0] mag;
    begin
      c = raw;
      if (c > `COEF_MAX)
        c = `COEF_MAX;
      if (c < `COEF_MIN)
        c = `COEF_MIN;
      mag = (c < `COEF_ZERO) ? -c : c;
      if (mag >= `COEF_FINE_LIM) begin
        mag = mag - (mag % `COEF_UNITY); // whole-unit step in the coarse range
        c = (c < `COEF_ZERO) ? -mag : mag;
      end
      legalCoef = c;
    end
  endfunction

  // legal coefficient values, ready for the next boundary
  wire signed [`COEF_W-1:0] coefALegal = legalCoef(coefA);
  wire signed [`COEF_W-1:0] coefBLegal = legalCoef(coefB);
  wire signed [`COEF_W-1:0] coefCLegal = legalCoef(coefC);
  wire signed [`COEF_W-1:0] coefDLegal = legalCoef(coefD);

  // settings move only at a boundary; a reset command between boundaries
  // is remembered so that a one-cycle pulse is never lost
  always @* begin
    cA_next        = cA_reg;
    cB_next        = cB_reg;
    cC_next        = cC_reg;
    cD_next        = cD_reg;
    inSw1_next     = inSw1_reg;
    inSw2_next     = inSw2_reg;
    outSw1_next    = outSw1_reg;
    outSw2_next    = outSw2_reg;
    en1_next       = en1_reg;
    en2_next       = en2_reg;
    inOff1_next    = inOff1_reg;
    inOff2_next    = inOff2_reg;
    outOff1_next   = outOff1_reg;
    outOff2_next   = outOff2_reg;
    pendReset_next = pendReset_reg | settingsReset;
    if (tick) begin
      pendReset_next = 1'b0;
      if (settingsReset || pendReset_reg) begin
        cA_next      = `COEF_UNITY;
        cB_next      = `COEF_ZERO;
        cC_next      = `COEF_ZERO;
        cD_next      = `COEF_UNITY;
        inSw1_next   = `SWITCH_CLOSED;
        inSw2_next   = `SWITCH_CLOSED;
        outSw1_next  = `SWITCH_CLOSED;
        outSw2_next  = `SWITCH_CLOSED;
        en1_next     = `ENABLE_OFF;
        en2_next     = `ENABLE_OFF;
        inOff1_next  = `SAMPLE_ZERO;
        inOff2_next  = `SAMPLE_ZERO;
        outOff1_next = `SAMPLE_ZERO;
        outOff2_next = `SAMPLE_ZERO;
      end else begin
        cA_next      = coefALegal;
        cB_next      = coefBLegal;
        cC_next      = coefCLegal;
        cD_next      = coefDLegal;
        inSw1_next   = inSwitchOne;
        inSw2_next   = inSwitchTwo;
        outSw1_next  = outSwitchOne;
        outSw2_next  = outSwitchTwo;
        en1_next     = outEnableOne;
        en2_next     = outEnableTwo;
        inOff1_next  = inOffsetOne;
        inOff2_next  = inOffsetTwo;
        outOff1_next = outOffsetOne;
        outOff2_next = outOffsetTwo;
      end
    end
  end

  // settings registers; power-on values equal the reset command's defaults
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cA_reg        <= `COEF_UNITY;
      cB_reg        <= `COEF_ZERO;
      cC_reg        <= `COEF_ZERO;
      cD_reg        <= `COEF_UNITY;
      inSw1_reg     <= `SWITCH_CLOSED;
      inSw2_reg     <= `SWITCH_CLOSED;
      outSw1_reg    <= `SWITCH_CLOSED;
      outSw2_reg    <= `SWITCH_CLOSED;
      en1_reg       <= `ENABLE_OFF;
      en2_reg       <= `ENABLE_OFF;
      inOff1_reg    <= `SAMPLE_ZERO;
      inOff2_reg    <= `SAMPLE_ZERO;
      outOff1_reg   <= `SAMPLE_ZERO;
      outOff2_reg   <= `SAMPLE_ZERO;
      pendReset_reg <= 1'b0;
    end else begin
      cA_reg        <= cA_next;
      cB_reg        <= cB_next;
      cC_reg        <= cC_next;
      cD_reg        <= cD_next;
      inSw1_reg     <= inSw1_next;
      inSw2_reg     <= inSw2_next;
      outSw1_reg    <= outSw1_next;
      outSw2_reg    <= outSw2_next;
      en1_reg       <= en1_next;
      en2_reg       <= en2_next;
      inOff1_reg    <= inOff1_next;
      inOff2_reg    <= inOff2_next;
      outOff1_reg   <= outOff1_next;
      outOff2_reg   <= outOff2_next;
      pendReset_reg <= pendReset_next;
    end
  end

  // saturating clip of a wide product sum down to a sample
  function signed [`SAMPLE_W-1:0] clipSample;
    input signed [`PROD_W:0] v;
    begin
      if (v > $signed({{(`PROD_W-`SAMPLE_W+1){1'b0}}, `SAMPLE_MAX}))
        clipSample = `SAMPLE_MAX;
      else if (v < $signed({{(`PROD_W-`SAMPLE_W+1){1'b1}}, `SAMPLE_MIN}))
        clipSample = `SAMPLE_MIN;
      else
        clipSample = v[`SAMPLE_W-1:0];
    end
  endfunction

  // matrix products; coefficient is in tenths, so divide the sum by ten
  wire signed [`PROD_W-1:0] pA  = inputOneSample * cA_reg;
  wire signed [`PROD_W-1:0] pB  = inputTwoSample * cB_reg;
  wire signed [`PROD_W-1:0] pC  = inputOneSample * cC_reg;
  wire signed [`PROD_W-1:0] pD  = inputTwoSample * cD_reg;
  // all operands signed, so the sum extends and divides toward zero
  wire signed [`PROD_W:0]   s1  = (pA + pB) / `COEF_UNITY;
  wire signed [`PROD_W:0]   s2  = (pC + pD) / `COEF_UNITY;
  wire signed [`SAMPLE_W-1:0] mix1 = clipSample(s1);
  wire signed [`SAMPLE_W-1:0] mix2 = clipSample(s2);

  // input switch zeroes the mixed signal ahead of the offset
  wire signed [`SAMPLE_W-1:0] gated1 = inSw1_reg ? mix1 : `SAMPLE_ZERO;
  wire signed [`SAMPLE_W-1:0] gated2 = inSw2_reg ? mix2 : `SAMPLE_ZERO;
  wire signed [`SAMPLE_W-1:0] first_controller_path;
  wire signed [`SAMPLE_W-1:0] second_controller_path;
  wire signed [`SAMPLE_W-1:0] out1;
  wire signed [`SAMPLE_W-1:0] out2;

  // input offsets, saturating
  mix_sat_add uInOff1 (.opA(gated1), .opB(inOff1_reg), .sum(first_controller_path));
  mix_sat_add uInOff2 (.opA(gated2), .opB(inOff2_reg), .sum(second_controller_path));

  // output switch forces zero before the output offset is added
  mix_sat_add uOutOff1 (.opA(outSw1_reg ? ctrlOneSample : `SAMPLE_ZERO), .opB(outOff1_reg), .sum(out1));
  mix_sat_add uOutOff2 (.opA(outSw2_reg ? ctrlTwoSample : `SAMPLE_ZERO), .opB(outOff2_reg), .sum(out2));

  // all stream outputs update together on the strobe
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      firstControllerPath  <= `SAMPLE_ZERO;
      secondControllerPath <= `SAMPLE_ZERO;
      prePathOne           <= `SAMPLE_ZERO;
      prePathTwo           <= `SAMPLE_ZERO;
      chanOneOut           <= `SAMPLE_ZERO;
      chanTwoOut           <= `SAMPLE_ZERO;
      chanOneDrive         <= 1'b0;
      chanTwoDrive         <= 1'b0;
    end else if (tick) begin
      firstControllerPath  <= first_controller_path;
      secondControllerPath <= second_controller_path;
      prePathOne           <= mix1;
      prePathTwo           <= mix2;
      chanOneOut           <= en1_reg ? out1 : `SAMPLE_ZERO;
      chanTwoOut           <= en2_reg ? out2 : `SAMPLE_ZERO;
      chanOneDrive         <= en1_reg;
      chanTwoDrive         <= en2_reg;
    end
  end

endmodule
`default_nettype wire

/* hw/input_mixer_consts.vh */
// constants for the dual path input mixer
// assumes 16-bit signed samples where full scale spans -1 V to +1 V
`ifndef INPUT_MIXER_CONSTS_VH
`define INPUT_MIXER_CONSTS_VH

// sample and coefficient formats
`define SAMPLE_W        16
`define COEF_W          9
`define PROD_W          25
`define COEF_SHIFT      4'd1
`define COEF_MAX        9'sh0C8
`define COEF_MIN        -9'sh0C8
`define COEF_FINE_LIM   9'sh064
`define COEF_UNITY      9'sh00A
`define COEF_ZERO       9'sh000
`define SAMPLE_MAX      16'sh7FFF
`define SAMPLE_MIN      16'sh8000
`define SAMPLE_ZERO     16'sh0000
`define SWITCH_CLOSED   1'b1
`define ENABLE_OFF      1'b0

// output sample rate: 40 MHz system clock, 2.5 MSa/s
`define CLK_HZ          40000000
`define SAMPLE_HZ       2500000
`define RATE_DIV        (`CLK_HZ / `SAMPLE_HZ)
`define RATE_CNT_W      4
`define RATE_CNT_ZERO   4'h0
`define RATE_CNT_LAST   4'hF
`define RATE_CNT_STEP   4'h1

`endif

/* hw/mix_sat_add.v */
// signed adder with saturation to the sample range
// assumes both operands already clipped to the sample range
`timescale 1ns/100ps
`default_nettype none
`include "input_mixer_consts.vh"

module mix_sat_add (
  // operands
  input  wire signed [`SAMPLE_W-1:0] opA,
  input  wire signed [`SAMPLE_W-1:0] opB,
  // clipped sum
  output wire signed [`SAMPLE_W-1:0] sum
);

  wire signed [`SAMPLE_W:0] wide;

  // one guard bit catches any overflow of two in-range operands
  assign wide = {opA[`SAMPLE_W-1], opA} + {opB[`SAMPLE_W-1], opB};
  // bounds cast to signed so a negative sum is not compared as a huge number
  assign sum  = (wide > $signed({1'b0, `SAMPLE_MAX})) ? `SAMPLE_MAX :
                (wide < $signed({1'b1, `SAMPLE_MIN})) ? `SAMPLE_MIN : wide[`SAMPLE_W-1:0];

endmodule
`default_nettype wire

/* tb/ctrl_filter_model.sv */
// stand-in for the two controller filters behind the mixer
// assumes samples move on sampleStrobe; unity gain, one sample late
`timescale 1ns/100ps
`default_nettype none
module ctrl_filter_model (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  // path samples in, filtered samples out
  input  wire logic               sampleStrobe,
  input  wire logic signed [15:0] firstControllerPath,
  input  wire logic signed [15:0] secondControllerPath,
  output logic signed [15:0]      ctrlOneSample,
  output logic signed [15:0]      ctrlTwoSample
);
  // a real filter lags at least one sample, so no zero-delay path is offered
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      {ctrlOneSample, ctrlTwoSample} <= 32'h00000000;
    end else if (sampleStrobe) begin
      {ctrlOneSample, ctrlTwoSample} <= {firstControllerPath, secondControllerPath};
    end
  end
endmodule
`default_nettype wire

/* tb/dual_path_input_mixer_assertions.sv */
// port checker for the dual path input mixer
// assumes one clock domain; bound to the mixer below
`timescale 1ns/100ps
`default_nettype none
module mixer_checker (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               resetn,
  // mixer outputs
  input wire logic               sampleStrobe,
  input wire logic signed [15:0] firstControllerPath,
  input wire logic signed [15:0] secondControllerPath,
  input wire logic signed [15:0] prePathOne,
  input wire logic signed [15:0] prePathTwo,
  input wire logic signed [15:0] chanOneOut,
  input wire logic signed [15:0] chanTwoOut,
  input wire logic               chanOneDrive,
  input wire logic               chanTwoDrive
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // clocks since last strobe, held at 31 so a dead strobe stays visible
  logic [4:0] strobeGap_reg;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) strobeGap_reg <= 5'h00;
    else if (sampleStrobe) strobeGap_reg <= 5'h01;
    else if (strobeGap_reg != 5'h00 && strobeGap_reg != 5'h1F) strobeGap_reg <= strobeGap_reg + 5'h01;
  end
  strobe_single_a: assert property (sampleStrobe |=> !sampleStrobe [*8]) else $error("strobe too wide");
  strobe_early_a: assert property (sampleStrobe && strobeGap_reg != 5'h00 |-> strobeGap_reg == 5'h10)
    else $error("strobe early");
  strobe_late_a: assert property (strobeGap_reg < 5'h11) else $error("strobe late");
  reset_clear_a: assert property ($rose(resetn) |-> !(|{chanOneOut, chanTwoOut, chanOneDrive, chanTwoDrive}))
    else $error("outputs not cleared");
  tap_hold_a: assert property (!sampleStrobe |-> $stable({prePathOne, prePathTwo})) else $error("tap moved");
  path_hold_a: assert property (!sampleStrobe |-> $stable({firstControllerPath, secondControllerPath}))
    else $error("path moved");
  chan_hold_a: assert property (!sampleStrobe |-> $stable({chanOneOut, chanTwoOut, chanOneDrive, chanTwoDrive}))
    else $error("channel moved");
  drive_zero_a: assert property ((chanOneDrive || chanOneOut == 16'sh0000) && (chanTwoDrive || chanTwoOut == 16'sh0000))
    else $error("undriven channel not zero");
endmodule
bind dual_path_input_mixer mixer_checker mixer_checker_inst (.clk_sys, .resetn, .sampleStrobe, .firstControllerPath,
  .secondControllerPath, .prePathOne, .prePathTwo, .chanOneOut, .chanTwoOut, .chanOneDrive, .chanTwoDrive);
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the dual path input mixer
// assumes the bound checker and a unity-gain filter model on the far side
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin totalChecks++; if ((got) !== (ex)) begin numErrors++; \
  $display("BAD %s expected %h seen %h", nm, ex, got); end end
module testbench;
  // stimulus and observed signals carry the mixer port names
  logic               clk_sys = 1'b0, resetn = 1'b0, settingsReset = 1'b0, sampleStrobe, chanOneDrive, chanTwoDrive;
  logic               inSwitchOne = 1'b1, inSwitchTwo = 1'b1, outSwitchOne = 1'b1, outSwitchTwo = 1'b1;
  logic               outEnableOne = 1'b0, outEnableTwo = 1'b0;
  logic signed [8:0]  coefA = 9'sh00A, coefB = 9'sh000, coefC = 9'sh000, coefD = 9'sh00A;
  logic signed [15:0] inputOneSample = 16'sh0000, inputTwoSample = 16'sh0000, inOffsetOne = 16'sh0000;
  logic signed [15:0] inOffsetTwo = 16'sh0000, outOffsetOne = 16'sh0000, outOffsetTwo = 16'sh0000;
  logic signed [15:0] ctrlOneSample, ctrlTwoSample, chanOneOut, chanTwoOut, prePathOne, prePathTwo;
  logic signed [15:0] firstControllerPath, secondControllerPath;
  int                 numErrors = 0, totalChecks = 0;
  // 40 MHz clock, mixer and filter model
  always #12.5 clk_sys = ~clk_sys;
  dual_path_input_mixer dual_path_input_mixer_inst (.*);
  ctrl_filter_model ctrl_filter_model_inst (.*);
  function automatic logic signed [15:0] sat(input int v);
    return (v > 32767) ? 16'sh7FFF : (v < -32768) ? 16'sh8000 : 16'(v);
  endfunction
  function automatic int clampc(input int v);
    v = (v > 200) ? 200 : (v < -200) ? -200 : v;
    return (v >= 100 || v <= -100) ? v / 10 * 10 : v;
  endfunction
  // wait for n strobes; a missing one counts against the design
  task automatic strobes(input int n);
    int k;
    repeat (n) begin
      k = 0;
      @(posedge clk_sys);
      #1;
      while (k < 40 && sampleStrobe !== 1'b1) begin
        @(posedge clk_sys);
        #1;
        k++;
      end
      `CHK("sampleStrobe", 1'b1, sampleStrobe)
    end
  endtask
  // apply one setting set, let it pass the filter loop, then compare
  task automatic scen(input int a, b, c, d, x, y, io, oo, input logic [1:0] si, so, en);
    logic signed [15:0] p1, p2, q1, q2, o1, o2;
    p1 = sat((clampc(a) * x + clampc(b) * y) / 10);
    p2 = sat((clampc(c) * x + clampc(d) * y) / 10);
    q1 = sat((si[0] ? int'(p1) : 0) + io);
    q2 = sat((si[1] ? int'(p2) : 0) - io);
    o1 = en[0] ? sat((so[0] ? int'(q1) : 0) + oo) : 16'sh0000;
    o2 = en[1] ? sat((so[1] ? int'(q2) : 0) - oo) : 16'sh0000;
    @(posedge clk_sys);
    {coefA, coefB, coefC, coefD} <= {9'(a), 9'(b), 9'(c), 9'(d)};
    {inputOneSample, inputTwoSample, inOffsetOne, inOffsetTwo} <= {16'(x), 16'(y), 16'(io), 16'(-io)};
    {outOffsetOne, outOffsetTwo} <= {16'(oo), 16'(-oo)};
    {inSwitchTwo, inSwitchOne, outSwitchTwo, outSwitchOne, outEnableTwo, outEnableOne} <= {si, so, en};
    strobes(5);
    `CHK("prePath", {p1, p2}, {prePathOne, prePathTwo})
    `CHK("controllerPath", {q1, q2}, {firstControllerPath, secondControllerPath})
    `CHK("chanOut", {o1, o2}, {chanOneOut, chanTwoOut})
    `CHK("chanDrive", en, {chanTwoDrive, chanOneDrive})
  endtask
  // main sequence; settings reset pulsed while ports hold defaults
  initial begin
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    settingsReset <= 1'b1;
    @(posedge clk_sys);
    settingsReset <= 1'b0;
    scen(10, 0, 0, 10, 1234, -4321, 0, 0, 3, 3, 3);
    scen(10, 10, 0, 20, 1000, 2000, 0, 0, 3, 3, 3);
    scen(-5, 3, 7, -9, 12345, -23456, 0, 0, 3, 3, 2);
    scen(255, -256, 155, -137, 3000, 1000, 0, 0, 3, 3, 1);
    scen(200, 200, -200, -200, 32767, 32767, 0, 0, 3, 3, 3);
    scen(15, -7, 3, 4, 2000, 500, 100, 0, 0, 3, 3);
    scen(15, -7, 3, 4, 2000, 500, 32000, -500, 3, 0, 1);
    // reset command while live settings stay on the ports: defaults rule one period
    @(posedge clk_sys);
    settingsReset <= 1'b1;
    @(posedge clk_sys);
    settingsReset <= 1'b0;
    strobes(2);
    `CHK("resetPrePath", {16'sh07D0, 16'sh01F4}, {prePathOne, prePathTwo})
    `CHK("resetPath", {16'sh07D0, 16'sh01F4}, {firstControllerPath, secondControllerPath})
    `CHK("resetChan", 34'h000000000, {chanOneDrive, chanTwoDrive, chanOneOut, chanTwoOut})
    report_and_stop;
  end
  // run takes about 600 clocks; 3000 means a hang
  initial begin
    repeat (3000) @(posedge clk_sys);
    numErrors++;
    report_and_stop;
  end
  task automatic report_and_stop;
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
endmodule
`default_nettype wire
